// file: rtl/bshf_pkg.sv
// Package: register map, field positions and framing constants of the framer
package bshf_pkg;
    // ==========================================
    // Register byte offsets
    localparam logic [7:0] PARAM_OFS = 8'h00;
    localparam logic [7:0] RXCSR_OFS = 8'h04;
    localparam logic [7:0] RXBUF_OFS = 8'h08;
    localparam logic [7:0] TXCSR_OFS = 8'h0c;
    localparam logic [7:0] TXBUF_OFS = 8'h10;
    localparam logic [7:0] CRC_OFS = 8'h14;
    // ==========================================
    // Field positions
    localparam int PAR_BITMODE = 8;
    localparam int PAR_NOCRC = 9;
    localparam int RX_EN = 0;
    localparam int RX_IE = 6;
    localparam int RX_DONE = 7;
    localparam int RX_CRCZ = 14;
    localparam int RX_ERR = 15;
    localparam int TX_SEND = 4;
    localparam int TX_DONE = 7;
    localparam int TX_ABT = 9;
    localparam int TX_LATE = 15;
    localparam int TXB_EOM = 9;
    localparam int RXB_SOM = 8;
    localparam int RXB_EOM = 9;
    localparam int RXB_ABT = 10;
    localparam int RXB_CRCE = 11;
    // ==========================================
    // Framing and check constants
    localparam logic [7:0] FLAG_CHAR = 8'h7e;
    localparam logic [15:0] CCITT_POLY = 16'h8408;
    localparam logic [15:0] CRC16_POLY = 16'ha001;
    localparam logic [15:0] CCITT_GOOD = 16'hf0b8;
    localparam logic [15:0] CCITT_PRESET = 16'hffff;
    localparam logic [15:0] CRC16_PRESET = 16'h0000;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [3:0] FLAG_RUN = 4'h6;
    localparam logic [3:0] ABORT_RUN = 4'h7;
    localparam logic [4:0] CHAR_BITS = 5'h08;
    localparam logic [4:0] FCS_BITS = 5'h10;

    typedef enum logic [2:0] {
        BSHF_IDLE = 3'b000,
        BSHF_FLAG = 3'b001,
        BSHF_DATA = 3'b010,
        BSHF_FCS = 3'b011,
        BSHF_ABORT = 3'b100
    } bshf_tx_state_t;

    // One bit of a reflected CRC, LSB first
    function automatic logic [15:0] bshf_crc_bit(logic [15:0] c, logic b, logic [15:0] p);
        bshf_crc_bit = (c[0] ^ b) ? ((c >> 1) ^ p) : (c >> 1);
    endfunction

    function automatic logic [15:0] bshf_crc_byte(logic [15:0] c, logic [7:0] d, logic [15:0] p);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
            r = bshf_crc_bit(r, d[i], p);
        bshf_crc_byte = r;
    endfunction
endpackage

// file: rtl/bshf_top.sv
// Bit-synchronous framer: AHB-Lite registers, serial transmitter and receiver
// Function
// R1: Data between flags handled as 8-bit characters
// R2: Finished character reloads shift register from buffer
// R3: Empty buffer: mark; bit mode underrun and abort
// R4: Insert zero after five sent ones
// R5: Drop zero after five received ones
// R6: Flags sent and found without stuffing
// R7: Hardware appends 16-bit check sequence
// R8: Bit mode check error in buffer entry
// R9: Count mode: software reads accumulated CRC
// R10: Bit mode CCITT, preset all ones
// R11: Bit mode sends complemented CRC
// R12: Other modes use CRC-16 unless disabled
// R13: More than seven ones is abort
// R14: Abort ends frame, sets error and done
// R15: Receive done with enable raises interrupt
// R16: Abort control held sends abort sequences
// R17: Late reload sets flag, idles aborts
// R18: Program sends two SYNs, fills gaps
// R19: Pad gap at least fourteen characters
// R20: Program builds header, count and CRCs
// R21: Flag pattern 01111110 opens and closes frames
// R22: End of message: char, CRC, flag
// R23: CRC disable bit stops generate and check
// R24: Abort character is eight unstuffed ones
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module bshf_top
    import bshf_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Serial line
    input wire logic tx_clk_in,
    input wire logic rx_clk_in,
    input wire logic rx_data_in,
    output logic tx_data_out,
    // Interrupt
    output logic rx_irq
);
    import bshf_pkg::*;

    // ==========================================
    // Bus slave
    logic ap_reg, ap_wr_reg;
    logic [7:0] ap_addr_reg;
    logic [31:0] hrdata_reg;
    logic bitmode_reg, nocrc_reg, rx_en_reg, rx_ie_reg, send_reg, abt_ctl_reg;
    logic rx_done_reg, rx_err_reg, tx_late_reg, tx_full_reg, tx_beom_reg, irq_reg;
    logic [7:0] tx_buf_reg;
    logic [11:0] rx_buf_reg;
    logic [15:0] rx_crc_reg;
    wire addr_ph = hsel & hready & htrans[1];
    wire rd_ph = addr_ph & ~hwrite;
    wire wr_ph = ap_reg & ap_wr_reg;
    wire wr_par = wr_ph & (ap_addr_reg == PARAM_OFS);
    wire wr_rxcsr = wr_ph & (ap_addr_reg == RXCSR_OFS);
    wire wr_txcsr = wr_ph & (ap_addr_reg == TXCSR_OFS);
    wire wr_txbuf = wr_ph & (ap_addr_reg == TXBUF_OFS);
    wire rd_rxbuf = rd_ph & (haddr[7:0] == RXBUF_OFS) & (haddr[31:8] == 24'h0);
    wire tx_done = send_reg & ~tx_full_reg;
    logic [15:0] rd_mux;
    always_comb
    begin
        rd_mux = 16'h0;
        if (haddr[31:8] == 24'h0)
        begin
            unique case (haddr[7:0])
                PARAM_OFS: rd_mux = 16'(bitmode_reg) << PAR_BITMODE | 16'(nocrc_reg) << PAR_NOCRC;
                RXCSR_OFS: rd_mux = 16'(rx_en_reg) << RX_EN | 16'(rx_ie_reg) << RX_IE
                    | 16'(rx_done_reg) << RX_DONE | 16'(rx_err_reg) << RX_ERR
                    | 16'(rx_crc_reg == 16'h0) << RX_CRCZ; // R9
                RXBUF_OFS: rd_mux = {4'h0, rx_buf_reg};
                TXCSR_OFS: rd_mux = 16'(send_reg) << TX_SEND | 16'(tx_done) << TX_DONE
                    | 16'(abt_ctl_reg) << TX_ABT | 16'(tx_late_reg) << TX_LATE;
                CRC_OFS: rd_mux = rx_crc_reg; // R9
                default: rd_mux = 16'h0;
            endcase
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign rx_irq = irq_reg;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_reg <= 1'b0;
            ap_wr_reg <= 1'b0;
            ap_addr_reg <= 8'h0;
            hrdata_reg <= 32'h0;
            {bitmode_reg, nocrc_reg, rx_en_reg, rx_ie_reg, send_reg, abt_ctl_reg} <= 6'h0;
            irq_reg <= 1'b0;
        end
        else
        begin
            ap_reg <= addr_ph & (haddr[31:8] == 24'h0);
            ap_wr_reg <= hwrite;
            ap_addr_reg <= haddr[7:0];
            if (rd_ph)
                hrdata_reg <= {16'h0, rd_mux};
            if (wr_par)
            begin
                bitmode_reg <= hwdata[PAR_BITMODE];
                nocrc_reg <= hwdata[PAR_NOCRC]; // R23
            end
            if (wr_rxcsr)
            begin
                rx_en_reg <= hwdata[RX_EN];
                rx_ie_reg <= hwdata[RX_IE];
            end
            if (wr_txcsr)
            begin
                send_reg <= hwdata[TX_SEND];
                abt_ctl_reg <= hwdata[TX_ABT];
            end
            irq_reg <= rx_done_reg & rx_ie_reg; // R15
        end
    end

    // ==========================================
    // Line synchronisers; edges come from the second and third stages
    logic [2:0] txc_sh_reg, rxc_sh_reg;
    logic [1:0] rxd_sh_reg;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            txc_sh_reg <= 3'h0;
            rxc_sh_reg <= 3'h0;
            rxd_sh_reg <= 2'h3;
        end
        else
        begin
            txc_sh_reg <= {txc_sh_reg[1:0], tx_clk_in};
            rxc_sh_reg <= {rxc_sh_reg[1:0], rx_clk_in};
            rxd_sh_reg <= {rxd_sh_reg[0], rx_data_in};
        end
    end
    wire tx_step = txc_sh_reg[1] & ~txc_sh_reg[2];
    wire rx_step = rxc_sh_reg[1] & ~rxc_sh_reg[2];
    wire rx_bit = rxd_sh_reg[1];

    // ==========================================
    // Transmitter
    bshf_tx_state_t tx_state_reg;
    logic [15:0] tx_sh_reg, tx_crc_reg;
    logic [4:0] tx_cnt_reg;
    logic [2:0] tx_ones_reg;
    logic tx_eom_reg, tx_close_reg, tx_out_reg;
    wire [15:0] poly = bitmode_reg ? CCITT_POLY : CRC16_POLY; // R10 R12
    // A run of five ones that ends the check sequence still gets its zero before the flag
    wire stuff_en = bitmode_reg & ((tx_state_reg inside {BSHF_DATA, BSHF_FCS})
        | (tx_state_reg == BSHF_FLAG & tx_close_reg & tx_cnt_reg == CHAR_BITS)); // R6
    wire stuff_now = stuff_en & (tx_ones_reg == STUFF_RUN); // R4
    wire last_bit = (tx_cnt_reg == 5'h01) & ~stuff_now;
    wire tx_load = tx_step & last_bit & ~abt_ctl_reg & tx_full_reg & ~tx_eom_reg
        & ((tx_state_reg == BSHF_DATA) | (tx_state_reg == BSHF_FLAG & ~tx_close_reg));
    wire tx_start = tx_step & (tx_state_reg == BSHF_IDLE) & send_reg & tx_full_reg;
    wire tx_under = tx_step & last_bit & (tx_state_reg == BSHF_DATA) & ~tx_eom_reg
        & ~tx_full_reg & ~abt_ctl_reg;
    // The last data bit is folded in before the check sequence is latched
    wire [15:0] crc_next = bshf_crc_bit(tx_crc_reg, tx_sh_reg[0], poly);
    wire [15:0] fcs = bitmode_reg ? ~crc_next : crc_next; // R11
    assign tx_data_out = tx_out_reg;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_full_reg <= 1'b0;
            tx_buf_reg <= 8'h0;
            tx_beom_reg <= 1'b0;
            tx_late_reg <= 1'b0;
        end
        else
        begin
            if (wr_txbuf)
            begin
                tx_buf_reg <= hwdata[7:0];
                tx_beom_reg <= hwdata[TXB_EOM]; // R22
            end
            if (wr_txbuf)
                tx_full_reg <= 1'b1;
            else if (tx_load | (tx_start & ~bitmode_reg))
                tx_full_reg <= 1'b0;
            if (tx_under & bitmode_reg)
                tx_late_reg <= 1'b1; // R3 R17
            else if (wr_txcsr & hwdata[TX_LATE])
                tx_late_reg <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_state_reg <= BSHF_IDLE;
            tx_sh_reg <= 16'h0;
            tx_crc_reg <= 16'h0;
            tx_cnt_reg <= 5'h0;
            tx_ones_reg <= 3'h0;
            tx_eom_reg <= 1'b0;
            tx_close_reg <= 1'b0;
            tx_out_reg <= 1'b1;
        end
        else if (tx_step)
        begin
            if (stuff_now)
            begin
                tx_out_reg <= 1'b0; // R4
                tx_ones_reg <= 3'h0;
            end
            else if (tx_state_reg == BSHF_IDLE)
            begin
                tx_out_reg <= 1'b1; // R3
                if (tx_full_reg & send_reg)
                begin
                    tx_crc_reg <= bitmode_reg ? CCITT_PRESET : CRC16_PRESET; // R10
                    tx_close_reg <= 1'b0;
                    tx_cnt_reg <= CHAR_BITS;
                    tx_state_reg <= bitmode_reg ? BSHF_FLAG : BSHF_DATA; // R21
                    tx_sh_reg <= {8'h0, bitmode_reg ? FLAG_CHAR : tx_buf_reg};
                    tx_eom_reg <= ~bitmode_reg & tx_beom_reg;
                end
            end
            else
            begin
                tx_out_reg <= (tx_state_reg == BSHF_ABORT) | tx_sh_reg[0]; // R24
                tx_ones_reg <= (stuff_en & tx_sh_reg[0]) ? tx_ones_reg + 3'h1 : 3'h0;
                tx_sh_reg <= tx_sh_reg >> 1;
                tx_cnt_reg <= tx_cnt_reg - 5'h01;
                if (tx_state_reg == BSHF_DATA & ~nocrc_reg)
                    tx_crc_reg <= crc_next; // R7
                if (last_bit)
                begin
                    tx_cnt_reg <= CHAR_BITS; // R1
                    if (abt_ctl_reg | (tx_state_reg == BSHF_ABORT & tx_late_reg) | tx_under)
                        tx_state_reg <= (bitmode_reg | abt_ctl_reg) ? BSHF_ABORT
                            : BSHF_IDLE; // R16 R17 R3
                    else if (tx_state_reg == BSHF_DATA & tx_eom_reg)
                    begin
                        tx_eom_reg <= 1'b0;
                        tx_close_reg <= 1'b1;
                        if (!nocrc_reg)
                        begin
                            tx_state_reg <= BSHF_FCS; // R22 R7
                            tx_sh_reg <= fcs;
                            tx_cnt_reg <= FCS_BITS;
                        end
                        else
                        begin
                            tx_state_reg <= bitmode_reg ? BSHF_FLAG : BSHF_IDLE; // R23
                            tx_sh_reg <= {8'h0, FLAG_CHAR};
                        end
                    end
                    else if (tx_state_reg == BSHF_FCS)
                    begin
                        tx_state_reg <= bitmode_reg ? BSHF_FLAG : BSHF_IDLE; // R22
                        tx_sh_reg <= {8'h0, FLAG_CHAR};
                    end
                    else if (tx_load)
                    begin
                        tx_state_reg <= BSHF_DATA; // R2
                        tx_sh_reg <= {8'h0, tx_buf_reg};
                        tx_eom_reg <= tx_beom_reg;
                    end
                    else if (tx_state_reg == BSHF_FLAG & ~tx_close_reg & send_reg)
                        tx_sh_reg <= {8'h0, FLAG_CHAR};
                    else
                        tx_state_reg <= BSHF_IDLE;
                end
            end
        end
    end

    // ==========================================
    // Receiver
    logic [3:0] rx_ones_reg;
    logic [7:0] rx_asm_reg;
    logic [2:0] rx_bits_reg;
    logic rx_inf_reg, rx_som_reg, rx_any_reg;
    wire rx_live = rx_step & rx_en_reg;
    wire rx_abort = rx_live & bitmode_reg & rx_bit & (rx_ones_reg == ABORT_RUN); // R13
    wire rx_flag = rx_live & bitmode_reg & ~rx_bit & (rx_ones_reg == FLAG_RUN); // R21
    wire rx_stuff = rx_live & bitmode_reg & ~rx_bit & (rx_ones_reg == {1'b0, STUFF_RUN}); // R5
    wire rx_dbit = rx_live & (~bitmode_reg | rx_inf_reg) & ~rx_flag & ~rx_stuff & ~rx_abort;
    wire rx_char = rx_dbit & (rx_bits_reg == 3'h7);
    wire [7:0] rx_byte = {rx_bit, rx_asm_reg[7:1]};
    wire rx_end = rx_flag & rx_inf_reg & rx_any_reg;
    wire rx_crce = bitmode_reg & ~nocrc_reg & (rx_crc_reg != CCITT_GOOD); // R8 R23
    wire rx_abt_ent = rx_abort & rx_inf_reg;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_ones_reg <= 4'h0;
            rx_asm_reg <= 8'h0;
            rx_bits_reg <= 3'h0;
            rx_inf_reg <= 1'b0;
            rx_som_reg <= 1'b0;
            rx_any_reg <= 1'b0;
            rx_crc_reg <= 16'h0;
            rx_buf_reg <= 12'h0;
            rx_done_reg <= 1'b0;
            rx_err_reg <= 1'b0;
        end
        else
        begin
            if (!rx_en_reg)
            begin
                rx_inf_reg <= 1'b0;
                rx_bits_reg <= 3'h0;
                rx_crc_reg <= CRC16_PRESET;
            end
            if (rx_live)
                rx_ones_reg <= ~rx_bit ? 4'h0 : (rx_ones_reg == 4'h8) ? 4'h8
                    : rx_ones_reg + 4'h1;
            if (rx_flag)
            begin
                rx_inf_reg <= 1'b1; // R6
                rx_bits_reg <= 3'h0;
                rx_som_reg <= 1'b1;
                rx_any_reg <= 1'b0;
                rx_crc_reg <= CCITT_PRESET; // R10
            end
            else if (rx_abort)
                rx_inf_reg <= 1'b0; // R14
            else if (rx_dbit)
            begin
                rx_asm_reg <= rx_byte;
                rx_bits_reg <= rx_bits_reg + 3'h1; // R1
                if (rx_char)
                begin
                    rx_som_reg <= 1'b0;
                    rx_any_reg <= 1'b1;
                    if (!nocrc_reg)
                        rx_crc_reg <= bshf_crc_byte(rx_crc_reg, rx_byte, poly); // R12
                end
            end
            if (rx_char)
                rx_buf_reg <= {3'h0, bitmode_reg & rx_som_reg, rx_byte};
            else if (rx_end)
                rx_buf_reg <= {rx_crce, 2'h1, 9'h0}; // R8
            else if (rx_abt_ent)
                rx_buf_reg <= {4'h4, 8'h0};
            if (rx_char | rx_end | rx_abt_ent)
                rx_done_reg <= 1'b1; // R14
            else if (rd_rxbuf)
                rx_done_reg <= 1'b0;
            if (rx_abt_ent)
                rx_err_reg <= 1'b1; // R14
            else if (wr_rxcsr & hwdata[RX_ERR])
                rx_err_reg <= 1'b0;
        end
    end

    // ==========================================
    // Checks
    sequence s_five_ones;
        tx_step && stuff_now;
    endsequence
    sequence s_abort_flags;
        rx_done_reg && rx_err_reg && !rx_inf_reg;
    endsequence

    AST_IRQ: assert property (@(posedge hclk) disable iff (!hresetn) // R15
        (rx_done_reg && rx_ie_reg) |=> rx_irq) else $error("irq missing");
    AST_STUFF: assert property (@(posedge hclk) disable iff (!hresetn) // R4
        s_five_ones |=> !tx_data_out && tx_ones_reg == 3'h0) else $error("no stuffed zero");
    AST_RXABORT: assert property (@(posedge hclk) disable iff (!hresetn) // R14
        rx_abt_ent |=> s_abort_flags) else $error("abort flags not set");
    AST_LATE: assert property (@(posedge hclk) disable iff (!hresetn) // R17
        (tx_under && bitmode_reg) |=> tx_late_reg && tx_state_reg == BSHF_ABORT)
        else $error("late underrun not handled");
    AST_MARK: assert property (@(posedge hclk) disable iff (!hresetn) // R3
        (tx_step && tx_state_reg == BSHF_IDLE) |=> tx_data_out) else $error("idle not mark");
    AST_TXABT: assert property (@(posedge hclk) disable iff (!hresetn) // R16
        (tx_step && last_bit && abt_ctl_reg) |=> tx_state_reg == BSHF_ABORT)
        else $error("abort control ignored");
    AST_CRCERR: assert property (@(posedge hclk) disable iff (!hresetn) // R8
        (rx_end && rx_crce) |=> rx_buf_reg[RXB_CRCE] && rx_buf_reg[RXB_EOM])
        else $error("crc error not reported");
    AST_LOAD: assert property (@(posedge hclk) disable iff (!hresetn) // R2
        (tx_load && !wr_txbuf) |=> !tx_full_reg && tx_state_reg == BSHF_DATA)
        else $error("buffer not loaded");
    AST_ABTONES: assert property (@(posedge hclk) disable iff (!hresetn) // R24
        (tx_step && tx_state_reg == BSHF_ABORT) |=> tx_data_out) else $error("abort not ones");
endmodule // bshf_top
`default_nettype wire

// file: test/bshf_line_model.sv
// Serial line partner: link clocks, transmit capture and receive bit source
`timescale 1ns/1ns
`default_nettype none
module bshf_line_model
(
    // Link clocks
    output logic tx_clk,
    output logic rx_clk,
    // Serial data
    input wire logic tx_data,
    output logic rx_data
);
    logic cap_q[$];
    logic snd_q[$];

    initial
    begin
        tx_clk = 1'b0;
        rx_clk = 1'b0;
        rx_data = 1'b1;
    end

    // Halves of 63 and 62 keep a 125 ns period on a 1 ns grid
    always
    begin
        #63 tx_clk = 1'b1;
        #62 tx_clk = 1'b0;
    end

    // Odd offset keeps the receive clock unrelated in phase to the others
    always
    begin
        #41 rx_clk = 1'b1;
        #62 rx_clk = 1'b0;
        #22;
    end

    // Sampled mid-bit, far from where the framer moves its output
    always @(negedge tx_clk)
        cap_q.push_back(tx_data);

    // Line rests at mark whenever nothing is queued
    always @(negedge rx_clk)
        rx_data <= (snd_q.size() > 0) ? snd_q.pop_front() : 1'b1;
endmodule // bshf_line_model
`default_nettype wire

// file: test/test_bit_sync_hdlc_framer.sv
// Self-checking bench of the framer: registers, transmit and receive frames
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        tests_run++; \
        if ((g) !== (e)) \
        begin \
            err_count++; \
            $display("[ERR] %s expected %h seen %h", nm, e, g); \
        end \
    end
module test_bit_sync_hdlc_framer;
    import bshf_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic tx_clk, rx_clk, rx_data, tx_data, rx_irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int err_count, tests_run, cyc;
    logic e_q[$];
    logic [7:0] ofs[4] = '{PARAM_OFS, RXCSR_OFS, TXCSR_OFS, CRC_OFS};

    bshf_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .tx_clk_in(tx_clk), .rx_clk_in(rx_clk), .rx_data_in(rx_data),
        .tx_data_out(tx_data), .rx_irq(rx_irq));
    bshf_line_model line (.tx_clk(tx_clk), .rx_clk(rx_clk), .tx_data(tx_data),
        .rx_data(rx_data));

    always #2 hclk = ~hclk;

    // ==========================================
    // Verdict and hang guard
    task automatic print_verdict();
        if (err_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            err_count++;
            print_verdict();
        end
    end

    // ==========================================
    // Bus access and line helpers
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 100);
        rd = hrdata;
    endtask

    task automatic rc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
        input string nm);
        bus(1'b0, a, 32'h0);
        `CHK(nm, e, rd & m)
    endtask

    task automatic poll(input logic [31:0] a, input int b);
        int n;
        n = 0;
        do bus(1'b0, a, 32'h0); while (rd[b] !== 1'b1 && ++n < 3000);
    endtask

    task automatic rx_entry(input logic [31:0] e);
        poll(RXCSR_OFS, RX_DONE);
        rc(RXBUF_OFS, 32'hfff, e, "rx entry");
    endtask

    // Bits go out LSB first; stuffing counts ones across field borders
    function automatic void put(ref logic q[$], input logic [23:0] v, input int nb,
        input bit stf, ref int run);
        for (int i = 0; i < nb; i++)
        begin
            q.push_back(v[i]);
            run = v[i] ? run + 1 : 0;
            if (stf && run == 5)
            begin
                q.push_back(1'b0);
                run = 0;
            end
        end
    endfunction

    function automatic logic [15:0] crc(logic [15:0] c, logic [7:0] d, logic [15:0] p);
        for (int i = 0; i < 8; i++)
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ p) : (c >> 1);
        return c;
    endfunction

    // Line idles at mark, so the first zero seen opens the expected stream
    task automatic cap_chk(input string nm);
        int z, n;
        z = -1;
        for (n = 0; n < 8000 && (z < 0 || line.cap_q.size() < z + e_q.size()); n++)
        begin
            @(posedge hclk);
            for (int i = 0; i < line.cap_q.size() && z < 0; i++)
                if (line.cap_q[i] === 1'b0)
                    z = i;
        end
        if (z < 0)
            z = 0;
        foreach (e_q[i])
            `CHK(nm, e_q[i], line.cap_q[z + i])
        bus(1'b1, TXCSR_OFS, 32'h8000);
        // Mark gap of over fourteen characters parts messages and lets flags drain
        repeat (3600) @(posedge hclk);
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        int run;
        logic [15:0] c;
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        err_count = 0;
        tests_run = 0;
        cyc = 0;
        run = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (ofs[i])
            rc(ofs[i], 32'hffffffff, 32'(ofs[i] == RXCSR_OFS) << RX_CRCZ, "reset value");
        bus(1'b1, PARAM_OFS, 32'h300);
        bus(1'b1, 32'h100, 32'hffff);
        rc(32'h100, 32'hffffffff, 32'h0, "unmapped");
        rc(PARAM_OFS, 32'hffffffff, 32'h300, "param");
        bus(1'b1, TXCSR_OFS, 32'h200);
        rc(TXCSR_OFS, 32'h200, 32'h200, "tx abort ctl");
        // ==========================================
        // Bit mode frame with back-to-back reload
        bus(1'b1, PARAM_OFS, 32'h100);
        bus(1'b1, TXBUF_OFS, 32'hff);
        line.cap_q.delete();
        bus(1'b1, TXCSR_OFS, 32'h10);
        poll(TXCSR_OFS, TX_DONE);
        bus(1'b1, TXBUF_OFS, 32'h241);
        c = crc(crc(16'hffff, 8'hff, CCITT_POLY), 8'h41, CCITT_POLY);
        e_q.delete();
        run = 0;
        put(e_q, FLAG_CHAR, 8, 0, run);
        put(e_q, 24'h41ff, 16, 1, run);
        put(e_q, ~c, 16, 1, run);
        put(e_q, FLAG_CHAR, 8, 0, run);
        cap_chk("bit mode tx");
        // ==========================================
        // Character mode with CRC-16, then with CRC disabled
        for (int k = 0; k < 2; k++)
        begin
            bus(1'b1, PARAM_OFS, k ? 32'h200 : 32'h0);
            // Two sync characters lead the message
            bus(1'b1, TXBUF_OFS, 32'h16);
            line.cap_q.delete();
            bus(1'b1, TXCSR_OFS, 32'h10);
            poll(TXCSR_OFS, TX_DONE);
            bus(1'b1, TXBUF_OFS, 32'h16);
            poll(TXCSR_OFS, TX_DONE);
            bus(1'b1, TXBUF_OFS, 32'h240);
            e_q.delete();
            c = crc(crc(crc(16'h0, 8'h16, CRC16_POLY), 8'h16, CRC16_POLY), 8'h40, CRC16_POLY);
            c = k ? 16'hffff : c;
            put(e_q, 24'h1616, 16, 0, run);
            put(e_q, {c, 8'h40}, 24, 0, run);
            cap_chk("char mode tx");
        end
        // ==========================================
        // Underrun: no reload after the first character
        bus(1'b1, PARAM_OFS, 32'h100);
        bus(1'b1, TXBUF_OFS, 32'h55);
        bus(1'b1, TXCSR_OFS, 32'h10);
        poll(TXCSR_OFS, TX_LATE);
        rc(TXCSR_OFS, 32'h8290, 32'h8090, "tx late");
        bus(1'b1, TXCSR_OFS, 32'h8000);
        rc(TXCSR_OFS, 32'h8290, 32'h0, "tx late clear");
        // ==========================================
        // Receive: good then corrupted check sequence
        for (int k = 0; k < 2; k++)
        begin
            bus(1'b1, RXCSR_OFS, 32'h1);
            c = ~crc(16'hffff, 8'hff, CCITT_POLY) ^ 16'(k);
            e_q.delete();
            run = 0;
            put(e_q, FLAG_CHAR, 8, 0, run);
            put(e_q, {c, 8'hff}, 24, 1, run);
            put(e_q, FLAG_CHAR, 8, 0, run);
            line.snd_q = e_q;
            rx_entry(32'h1ff);
            rx_entry({24'h0, c[7:0]});
            rx_entry({24'h0, c[15:8]});
            rx_entry(32'h200 | (k << 11));
            bus(1'b1, RXCSR_OFS, 32'h0);
            `CHK("rx irq", 1'b0, rx_irq)
        end
        // ==========================================
        // Received abort with the interrupt enabled
        bus(1'b1, RXCSR_OFS, 32'h41);
        e_q.delete();
        put(e_q, {16'h0, FLAG_CHAR}, 16, 0, run);
        put(e_q, 24'hff, 8, 0, run);
        line.snd_q = e_q;
        rx_entry(32'h100);
        poll(RXCSR_OFS, RX_DONE);
        @(posedge hclk);
        `CHK("rx status", 32'h80c1, rd & 32'h80c1)
        `CHK("rx irq", 1'b1, rx_irq)
        rc(RXBUF_OFS, 32'h400, 32'h400, "abort entry");
        bus(1'b1, RXCSR_OFS, 32'h8000);
        rc(RXCSR_OFS, 32'h80c1, 32'h0, "rx err clear");
        print_verdict();
    end
endmodule // test_bit_sync_hdlc_framer
`default_nettype wire
